// >>> core/rcs_defs.vh
// Constants for the reset controller status and command block
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH
`define RCS_OFF_CMD 4'h0
`define RCS_OFF_STATUS 4'h4
`define RCS_OFF_MODE 4'h8
`define RCS_KEY 8'hA5
`define RCS_KEY_HI 31
`define RCS_KEY_LO 24
`define RCS_CMD_CPU 0
`define RCS_CMD_PERIPH 2
`define RCS_CMD_PIN 3
`define RCS_SR_EDGE 0
`define RCS_SR_CAUSE_LO 8
`define RCS_SR_CAUSE_HI 10
`define RCS_SR_LEVEL 16
`define RCS_SR_BUSY 17
`define RCS_MR_UREN 0
`define RCS_MR_UIEN 4
`define RCS_MR_LEN_LO 8
`define RCS_MR_LEN_HI 11
`define RCS_CAUSE_GENERAL 3'h0
`define RCS_CAUSE_WAKE 3'h1
`define RCS_CAUSE_WDOG 3'h2
`define RCS_CAUSE_SW 3'h3
`define RCS_CAUSE_USER 3'h4
`define RCS_SW_SLOW_CYCLES 2'h2
`define RCS_WD_SLOW_CYCLES 2'h2
`endif

// >>> core/rcs_ctrl.v
// Reset controller: register slave, pin sampling and reset arbitration
//
// Operation
// - No watchdog event during user reset
// - No software reset during user reset
// - Watchdog overrides software reset in progress
// - Pin low ignored during software reset
// - No software reset during watchdog reset
// - No user reset during watchdog reset
// - Busy bit 17 set during software command
// - Bit 16 shows sampled pin level
// - Bit 0 latches pin fall until read
// - Irq when edge, user reset off, enabled
// - Status read clears edge flag, irq
// - Cause field encodes five reset kinds
// - Status read keeps cause field
// - Command bits reset cpu, peripherals, pin
// - Wrong key discards whole write
// - Mode bit 0 enables pin user reset
// - Pin pulse lasts 2^(len+1) slow cycles
// - Status reset value reports power-up cause
// - Command writes ignored while busy
// - Software reset lasts two slow cycles
// - Priority wake, watchdog, software, user
// - Cause software only with cpu command
`default_nettype none
`include "rcs_defs.vh"
module rcs_ctrl #(
    parameter [2:0] POWER_CAUSE = 3'h0 // General or wake-up after power-up
) (
    input wire mclk_i, // Master clock, 125 MHz
    input wire nrst_i, // Async reset, active low
    input wire [3:0] avs_address_i, // Byte address
    input wire avs_read_i, // Read strobe
    input wire avs_write_i, // Write strobe
    input wire [31:0] avs_writedata_i, // Write data
    output reg [31:0] avs_readdata_o, // Read data
    output reg avs_waitrequest_o, // Stall
    input wire slow_clock_i, // Slow clock level, sampled
    input wire wake_reset_i, // Main supply wake-up reset request
    input wire wdog_fault_i, // Watchdog fault, same domain
    input wire pin_reset_n_i, // External reset pin level
    output reg pin_reset_oe_o, // Pin drive enable, drives low
    output reg cpu_reset_o, // Processor reset, active high
    output reg periph_reset_o, // Peripheral reset, active high
    output reg irq_o // Controller interrupt
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_USER = 4'h2;
    localparam [3:0] ST_SW = 4'h4;
    localparam [3:0] ST_WDOG = 4'h8;

    reg rst_s1_q;
    reg rst_n_q;
    reg [2:0] pin_sync_q;
    reg pin_prev_q;
    reg [2:0] slk_sync_q;
    reg slk_prev_q;
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [1:0] cnt_q;
    reg [1:0] cnt_d;
    reg sw_cpu_q;
    reg edge_q;
    reg [2:0] cause_q;
    reg uren_q;
    reg uien_q;
    reg [3:0] len_q;
    reg [16:0] pulse_q;
    reg done_q;
    reg phase_q;
    reg start_pin_q;
    reg own_q;

    // Reset release through two flops
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Pin and slow clock pass three flops; a change counts when the last two agree
    always @(posedge mclk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pin_sync_q <= 3'h7;
            pin_prev_q <= 1'b1;
            slk_sync_q <= 3'h0;
            slk_prev_q <= 1'b0;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[1:0], pin_reset_n_i};
            if (pin_sync_q[1] == pin_sync_q[2])
                pin_prev_q <= pin_sync_q[2];
            slk_sync_q <= {slk_sync_q[1:0], slow_clock_i};
            if (slk_sync_q[1] == slk_sync_q[2])
                slk_prev_q <= slk_sync_q[2];
        end
    end

    // Confirmed levels and events
    wire pin_lvl = (pin_sync_q[1] == pin_sync_q[2]) ? pin_sync_q[2] : pin_prev_q;
    wire pin_fall = pin_prev_q & ~pin_lvl;
    wire slk_rise = ~slk_prev_q & (slk_sync_q[1] == slk_sync_q[2]) & slk_sync_q[2];

    // Bus decode; single-cycle answer, waitrequest only low in the cycle after a request is taken
    wire acc = (avs_read_i | avs_write_i) & avs_waitrequest_o;
    wire key_ok = avs_writedata_i[`RCS_KEY_HI:`RCS_KEY_LO] == `RCS_KEY;
    wire wr_cmd = acc & avs_write_i & (avs_address_i == `RCS_OFF_CMD) & key_ok;
    wire wr_mode = acc & avs_write_i & (avs_address_i == `RCS_OFF_MODE) & key_ok;
    wire rd_stat = acc & avs_read_i & (avs_address_i == `RCS_OFF_STATUS);
    wire cmd_any = avs_writedata_i[`RCS_CMD_CPU] | avs_writedata_i[`RCS_CMD_PERIPH] | avs_writedata_i[`RCS_CMD_PIN];
    // Software command accepted only from idle; busy, user and watchdog resets block it, a held wake-up reset does not
    wire sw_go = wr_cmd & cmd_any & (state_q == ST_IDLE);
    // Pin low counts only when enabled and not our own pulse
    // The synchroniser lags the pin, so the mask outlives the drive
    wire user_req = uren_q & ~pin_lvl & ~pin_reset_oe_o & ~own_q;

    // Own drive masks pin lows until the pin is confirmed high again
    // Limitation: a button held across our pulse is not seen; only a new press after release counts
    always @(posedge mclk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            own_q <= 1'b0;
        else if (pin_reset_oe_o)
            own_q <= 1'b1;
        else if (pin_lvl)
            own_q <= 1'b0;
    end

    // Arbitration: wake-up beats everything, watchdog beats software and user
    always @*
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE:
            begin
                if (wdog_fault_i)
                begin
                    state_d = ST_WDOG;
                    cnt_d = `RCS_WD_SLOW_CYCLES;
                end
                else if (sw_go)
                begin
                    state_d = ST_SW;
                    cnt_d = `RCS_SW_SLOW_CYCLES;
                end
                else if (user_req)
                    state_d = ST_USER;
            end
            ST_USER:
            begin
                // Watchdog held in reset here, faults ignored
                if (pin_lvl)
                    state_d = ST_IDLE;
            end
            ST_SW:
            begin
                if (wdog_fault_i)
                begin
                    state_d = ST_WDOG;
                    cnt_d = `RCS_WD_SLOW_CYCLES;
                end
                else if (slk_rise)
                begin
                    cnt_d = cnt_q - 2'h1;
                    if (cnt_q == 2'h1)
                        state_d = ST_IDLE;
                end
            end
            ST_WDOG:
            begin
                if (slk_rise)
                begin
                    cnt_d = cnt_q - 2'h1;
                    if (cnt_q == 2'h1)
                        state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
                cnt_d = 2'h0;
            end
        endcase
    end

    // State, cause and reset outputs
    always @(posedge mclk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 2'h0;
            sw_cpu_q <= 1'b0;
            cause_q <= 3'h0;
            done_q <= 1'b0;
            cpu_reset_o <= 1'b0;
            periph_reset_o <= 1'b0;
        end
        else
        begin
            state_q <= wake_reset_i ? ST_IDLE : state_d;
            cnt_q <= cnt_d;
            if (!done_q)
            begin
                done_q <= 1'b1;
                cause_q <= POWER_CAUSE;
            end
            if (sw_go)
                sw_cpu_q <= avs_writedata_i[`RCS_CMD_CPU];
            // Cause is recorded when the processor reset is released, except wake-up, which is recorded while it is held
            if (wake_reset_i)
                cause_q <= `RCS_CAUSE_WAKE;
            else if (state_q == ST_WDOG && state_d == ST_IDLE)
                cause_q <= `RCS_CAUSE_WDOG;
            else if (state_q == ST_SW && state_d == ST_IDLE && sw_cpu_q)
                cause_q <= `RCS_CAUSE_SW;
            else if (state_q == ST_USER && state_d == ST_IDLE)
                cause_q <= `RCS_CAUSE_USER;
            cpu_reset_o <= wake_reset_i | (state_d == ST_USER) | (state_d == ST_WDOG) |
                ((state_d == ST_SW) & (sw_go ? avs_writedata_i[`RCS_CMD_CPU] : sw_cpu_q));
            periph_reset_o <= wake_reset_i | (state_d == ST_USER) | (state_d == ST_WDOG) |
                ((state_d == ST_SW) & (sw_go ? avs_writedata_i[`RCS_CMD_PERIPH] : periph_reset_o));
        end
    end

    // Pin pulse: 2^(len+1) slow clock rises; watchdog also pulses the pin
    always @(posedge mclk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pulse_q <= 17'h0;
            pin_reset_oe_o <= 1'b0;
            start_pin_q <= 1'b0;
        end
        else
        begin
            start_pin_q <= (sw_go & avs_writedata_i[`RCS_CMD_PIN]) | (state_q != ST_WDOG && state_d == ST_WDOG);
            if (start_pin_q)
            begin
                // Five-bit sum so a length of 15 does not wrap to zero
                pulse_q <= 17'h1 << ({1'b0, len_q} + 5'h01);
                pin_reset_oe_o <= 1'b1;
            end
            else if (pin_reset_oe_o && slk_rise)
            begin
                pulse_q <= pulse_q - 17'h1;
                if (pulse_q == 17'h1)
                    pin_reset_oe_o <= 1'b0;
            end
        end
    end

    // Registers, edge flag and bus answer; set wins over read-clear
    always @(posedge mclk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            edge_q <= 1'b0;
            uren_q <= 1'b0;
            uien_q <= 1'b0;
            len_q <= 4'h0;
            phase_q <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
            irq_o <= 1'b0;
        end
        else
        begin
            if (pin_fall)
                edge_q <= 1'b1;
            else if (rd_stat)
                edge_q <= 1'b0;
            if (wr_mode)
            begin
                uren_q <= avs_writedata_i[`RCS_MR_UREN];
                uien_q <= avs_writedata_i[`RCS_MR_UIEN];
                len_q <= avs_writedata_i[`RCS_MR_LEN_HI:`RCS_MR_LEN_LO];
            end
            irq_o <= (pin_fall | (edge_q & ~rd_stat)) & ~uren_q & uien_q;
            phase_q <= (avs_read_i | avs_write_i) & avs_waitrequest_o & ~phase_q;
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o & ~phase_q);
            avs_readdata_o <= 32'h0;
            if (avs_read_i && avs_address_i == `RCS_OFF_STATUS && avs_waitrequest_o && !phase_q)
            begin
                avs_readdata_o[`RCS_SR_EDGE] <= edge_q;
                avs_readdata_o[`RCS_SR_CAUSE_HI:`RCS_SR_CAUSE_LO] <= cause_q;
                avs_readdata_o[`RCS_SR_LEVEL] <= pin_lvl;
                avs_readdata_o[`RCS_SR_BUSY] <= (state_q == ST_SW);
            end
            else if (avs_read_i && avs_address_i == `RCS_OFF_MODE && avs_waitrequest_o && !phase_q)
            begin
                avs_readdata_o[`RCS_MR_UREN] <= uren_q;
                avs_readdata_o[`RCS_MR_UIEN] <= uien_q;
                avs_readdata_o[`RCS_MR_LEN_HI:`RCS_MR_LEN_LO] <= len_q;
            end
        end
    end
endmodule // rcs_ctrl
`default_nettype wire

// >>> test/rcs_ctrl_props.sv
// Checker on the reset controller ports
`default_nettype none
module rcs_ctrl_props (
    input wire mclk_i, // Clock
    input wire nrst_i, // Reset
    input wire [3:0] avs_address_i, // Addr
    input wire avs_read_i, // Read
    input wire avs_write_i, // Write
    input wire [31:0] avs_writedata_i, // Wdata
    input wire [31:0] avs_readdata_o, // Rdata
    input wire avs_waitrequest_o, // Stall
    input wire wdog_fault_i, // Fault
    input wire pin_reset_n_i, // Pin
    input wire pin_reset_oe_o, // Drive
    input wire cpu_reset_o, // Cpu
    input wire periph_reset_o, // Periph
    input wire irq_o // Irq
);
    // Quiet outputs and a good key
    wire idle = !(cpu_reset_o || periph_reset_o || pin_reset_oe_o);
    wire key = avs_writedata_i[31:24] == 8'hA5;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // Command taken with no reset running
    sequence s_cmd;
        avs_write_i && avs_waitrequest_o && avs_address_i == 4'h0 && idle && !wdog_fault_i;
    endsequence
    // Status answer after a settled pin, so sync delay is over
    sequence s_stat;
        $stable(pin_reset_n_i) [*8] ##0 (!avs_waitrequest_o && avs_read_i && avs_address_i == 4'h4);
    endsequence
    AST_CPU: assert property (s_cmd ##0 (key && avs_writedata_i[0]) |-> ##[1:3] cpu_reset_o)
        else $error("no cpu reset");
    AST_PERIPH: assert property (s_cmd ##0 (key && avs_writedata_i[2]) |-> ##[1:3] periph_reset_o)
        else $error("no periph reset");
    AST_PIN: assert property (s_cmd ##0 (key && avs_writedata_i[3]) |-> ##[1:4] pin_reset_oe_o)
        else $error("no pin drive");
    AST_NO_CPU: assert property (s_cmd ##0 (key && !avs_writedata_i[0]) |=> !cpu_reset_o [*6])
        else $error("cpu reset unasked");
    AST_BAD_KEY: assert property (s_cmd ##0 !key |=> idle [*4])
        else $error("bad key acted");
    AST_PIN_LEN: assert property ($rose(pin_reset_oe_o) |=> pin_reset_oe_o [*8])
        else $error("pin pulse short");
    AST_LEVEL: assert property (s_stat |-> avs_readdata_o[16] == pin_reset_n_i)
        else $error("pin level wrong");
    AST_IRQ_CLR: assert property (s_stat |-> ##[1:2] !irq_o)
        else $error("irq kept");
endmodule // rcs_ctrl_props
bind rcs_ctrl rcs_ctrl_props rcs_ctrl_props_inst (.mclk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .wdog_fault_i, .pin_reset_n_i, .pin_reset_oe_o,
    .cpu_reset_o, .periph_reset_o, .irq_o);
`default_nettype wire

// >>> test/rcs_far_model.sv
// Far side: slow oscillator and pulled-up reset pin
`default_nettype none
module rcs_far_model (
    input wire logic oe_i, // Controller pulls low
    input wire logic ext_low_i, // Button held
    output var logic slow_o, // Slow clock
    output wire logic pin_n_o // Pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Free-running, phase unrelated to the master clock
    initial slow_o = 1'b0;
    always #101.3 slow_o = ~slow_o;
    // Pull-up wins only when nobody pulls low
    assign pin_n_o = !(oe_i || ext_low_i);
endmodule // rcs_far_model
`default_nettype wire

// >>> test/rcs_ctrl_bench.sv
// Self-checking bench for the reset controller
`default_nettype none
`include "rcs_defs.vh"
module rcs_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SP = 25; // Slow period in master cycles
    logic mclk_i = 1'b0, nrst_i = 1'b0, rd = 1'b0, wr = 1'b0, wdog = 1'b0, ext_low = 1'b0, wake = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, q;
    wire [31:0] rd_o;
    wire wait_o, slow, pin_n, oe, cpu, per, irq;
    int err_count = 0, total_checks = 0, cnt;
    // Clock, design and far side
    always #4 mclk_i = ~mclk_i;
    rcs_far_model rcs_far_model_inst (.oe_i(oe), .ext_low_i(ext_low), .slow_o(slow), .pin_n_o(pin_n));
    rcs_ctrl #(.POWER_CAUSE(3'h1)) rcs_ctrl_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rd_o),
        .avs_waitrequest_o(wait_o), .slow_clock_i(slow), .wake_reset_i(wake), .wdog_fault_i(wdog),
        .pin_reset_n_i(pin_n), .pin_reset_oe_o(oe), .cpu_reset_o(cpu), .periph_reset_o(per), .irq_o(irq));
    task automatic test_done();
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %0t saw %h want %h", $time, s, e);
        end
    endtask
    // A used-up bound is a mismatch and ends the run
    task automatic tmo(input int n);
        if (n >= 300)
        begin
            chk(32'h1, 32'h0);
            test_done();
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_i);
    endtask
    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        do
        begin
            @(posedge mclk_i);
            n++;
        end while (wait_o !== 1'b0 && n < 300);
        q = rd_o;
        wr <= 1'b0;
        rd <= 1'b0;
        tmo(n);
    endtask
    task automatic st();
        bus(1'b0, 4'h4, 32'h0);
    endtask
    // Wait for every reset output to drop, timing the pin drive
    task automatic quiet();
        int n;
        n = 0;
        cnt = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
            cnt += oe;
        end while ((cpu | per | oe) !== 1'b0 && n < 300);
        tmo(n);
    endtask
    // Power-up state, mode key, pin edge with irq
    initial
    begin
        cyc(3);
        nrst_i <= 1'b1;
        cyc(4);
        st();
        chk(q & 32'h0003_0700, 32'h0001_0100);
        bus(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 4'h8, 32'h5A00_0011);
        bus(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 4'h8, 32'hA500_0010);
        ext_low <= 1'b1;
        cyc(10);
        chk(irq, 1'b1);
        chk(cpu, 1'b0);
        st();
        chk(q & 32'h0001_0701, 32'h0000_0101);
        ext_low <= 1'b0;
        cyc(3);
        chk(irq, 1'b0);
        cyc(6);
        st();
        chk(q & 32'h0001_0701, 32'h0001_0100);
        // Commands: bad key, busy, ignored while busy
        bus(1'b1, 4'h0, 32'h5A00_000D);
        cyc(4);
        chk({cpu, per, oe}, 3'h0);
        bus(1'b1, 4'h0, 32'hA500_0004);
        st();
        chk(q[17], 1'b1);
        chk({cpu, per}, 2'h1);
        bus(1'b1, 4'h0, 32'hA500_0001);
        cyc(2);
        chk(cpu, 1'b0);
        quiet();
        st();
        chk(q & 32'h0002_0700, 32'h0000_0100);
        // Cpu and pin command, pulse of four slow cycles
        bus(1'b1, 4'h8, 32'hA500_0101);
        bus(1'b1, 4'h0, 32'hA500_0009);
        quiet();
        chk(cnt >= 3 * SP - 3 && cnt <= 4 * SP + 3, 1'b1);
        st();
        chk(q[10:8], `RCS_CAUSE_SW);
        // Button reset refuses software commands
        ext_low <= 1'b1;
        cyc(60);
        chk(cpu, 1'b1);
        bus(1'b1, 4'h0, 32'hA500_0004);
        st();
        chk(q[17], 1'b0);
        ext_low <= 1'b0;
        quiet();
        st();
        chk(q[10:8], `RCS_CAUSE_USER);
        // Watchdog fault during a software reset
        bus(1'b1, 4'h0, 32'hA500_0001);
        cyc(5);
        wdog <= 1'b1;
        cyc(1);
        wdog <= 1'b0;
        quiet();
        st();
        chk(q[10:8], `RCS_CAUSE_WDOG);
        // Wake-up reset holds the processor and is recorded
        wake <= 1'b1;
        cyc(3);
        chk(cpu, 1'b1);
        wake <= 1'b0;
        quiet();
        st();
        chk(q[10:8], `RCS_CAUSE_WAKE);
        test_done();
    end
endmodule // rcs_ctrl_bench
`default_nettype wire
